// ==== design/sgpio_params.svh ====
`ifndef SGPIO_PARAMS_SVH
`define SGPIO_PARAMS_SVH
`define SGPIO_OFF_DATA 12'h000
`define SGPIO_OFF_DIR 12'h004
`define SGPIO_OFF_ANALOG 12'h008
`define SGPIO_OFF_STATUS 12'h00C
`define SGPIO_RST_DIR 6'h3F
`define SGPIO_RST_LATCH 6'h00
`define SGPIO_RST_ANALOG 6'h3F
`define SGPIO_PIN_LSB 0
`define SGPIO_PIN_MSB 5
`endif

// ==== design/sgpio_pkg.sv ====
`default_nettype none
package sgpio_pkg;
  localparam int SGPIO_NPINS = 6;
  typedef logic [SGPIO_NPINS-1:0] sgpio_pins_t;
  typedef struct packed {
    sgpio_pins_t out;
    sgpio_pins_t oe;
  } sgpio_drive_s;
  typedef enum logic [1:0] {
    SGPIO_IDLE   = 2'b01,
    SGPIO_ACCESS = 2'b10
  } sgpio_phase_e;
endpackage
`default_nettype wire

// ==== design/sgpio_pin_cell.sv ====
`include "sgpio_params.svh"
`default_nettype none
module sgpio_pin_cell
  import sgpio_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // configuration
  input  wire sgpio_pins_t latch_in,
  input  wire sgpio_pins_t dir_in,
  input  wire sgpio_pins_t analog_in,
  // pad side
  input  wire sgpio_pins_t pin_in,
  output var  sgpio_drive_s drive,
  output var  sgpio_pins_t  levels
);
  typedef struct packed {
    sgpio_drive_s drive;
    sgpio_pins_t  levels;
  } sgpio_cell_s;
  sgpio_cell_s st_r;
  sgpio_cell_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.drive.out = latch_in;
    // analog select only affects the input path
    st_nxt.drive.oe  = ~dir_in;
    st_nxt.levels    = pin_in & ~analog_in;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign drive  = st_r.drive;
  assign levels = st_r.levels;
endmodule
`default_nettype wire

// ==== design/sgpio_port.sv ====
// Added by the designer: register access over APB and the placing of the registers.
`include "sgpio_params.svh"
`default_nettype none
module sgpio_port
  import sgpio_pkg::*;
(
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // pins
  input  wire logic [5:0]  pin_i,
  output var  logic [5:0]  pin_o,
  output var  logic [5:0]  pin_oe
);
  typedef struct packed {
    sgpio_pins_t  latch;
    sgpio_pins_t  dir;
    sgpio_pins_t  analog;
    sgpio_phase_e phase;
    logic [31:0]  rdata;
    logic         ready;
    logic         err;
  } sgpio_state_s;

  sgpio_state_s st_r;
  sgpio_state_s st_nxt;
  sgpio_drive_s drive;
  sgpio_pins_t  levels;

  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == `SGPIO_OFF_DATA) || (a == `SGPIO_OFF_DIR) ||
               (a == `SGPIO_OFF_ANALOG) || (a == `SGPIO_OFF_STATUS);
  endfunction

  sgpio_pin_cell u_cell (
    .pclk      (pclk),
    .presetn   (presetn),
    .latch_in  (st_r.latch),
    .dir_in    (st_r.dir),
    .analog_in (st_r.analog),
    .pin_in    (pin_i),
    .drive     (drive),
    .levels    (levels)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.ready = 1'b0;
    st_nxt.err   = 1'b0;
    unique case (st_r.phase)
      SGPIO_IDLE: begin
        if (psel && !penable) begin
          st_nxt.phase = SGPIO_ACCESS;
          st_nxt.ready = 1'b1;
          st_nxt.err   = !addr_hit(paddr);
          st_nxt.rdata = 32'h0000_0000;
          if (!pwrite) begin
            unique case (paddr)
              // upper bits stay zero so reserved bits read as zero
              `SGPIO_OFF_DATA:   st_nxt.rdata = {26'h0, levels};
              `SGPIO_OFF_DIR:    st_nxt.rdata = {26'h0, st_r.dir};
              `SGPIO_OFF_ANALOG: st_nxt.rdata = {26'h0, st_r.analog};
              `SGPIO_OFF_STATUS: st_nxt.rdata = {26'h0, drive.oe};
              default:           st_nxt.rdata = 32'h0000_0000;
            endcase
          end
        end
      end
      SGPIO_ACCESS: begin
        st_nxt.phase = SGPIO_IDLE;
        if (psel && penable && pwrite) begin
          unique case (paddr)
            `SGPIO_OFF_DATA:   st_nxt.latch = pwdata[5:0];
            `SGPIO_OFF_DIR:    st_nxt.dir = pwdata[5:0];
            `SGPIO_OFF_ANALOG: st_nxt.analog = pwdata[5:0];
            default:           st_nxt.latch = st_r.latch;
          endcase
        end
      end
      default: st_nxt.phase = SGPIO_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.latch  <= `SGPIO_RST_LATCH;
      st_r.dir    <= `SGPIO_RST_DIR;
      st_r.analog <= `SGPIO_RST_ANALOG;
      st_r.phase  <= SGPIO_IDLE;
      st_r.rdata  <= 32'h0000_0000;
      st_r.ready  <= 1'b0;
      st_r.err    <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    prdata  = st_r.rdata;
    pready  = st_r.ready;
    pslverr = st_r.err;
    pin_o   = drive.out;
    pin_oe  = drive.oe;
  end

  AST_INPUT_TRISTATE: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.dir[0] && $stable(st_r.dir) |=> !pin_oe[0])
    else $error("input pin still driven");
  AST_OUTPUT_DRIVES: assert property (@(posedge pclk) disable iff (!presetn)
    !st_r.dir[1] && $stable(st_r.dir) && $stable(st_r.latch)
    |=> pin_oe[1] && pin_o[1] == $past(st_r.latch[1]))
    else $error("output pin not driving latch");
  AST_ANALOG_READS_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.analog[2] |=> !levels[2] || $fell(st_r.analog[2]))
    else $error("analog pin read nonzero");
  AST_DIGITAL_FOLLOWS_PIN: assert property (@(posedge pclk) disable iff (!presetn)
    !st_r.analog[3] |=> levels[3] == $past(pin_i[3]))
    else $error("digital level not sampled");
  AST_ANALOG_KEEPS_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.analog[4] && !st_r.dir[4] && $stable(st_r.dir) |=> pin_oe[4])
    else $error("analog select cut drive");
  AST_READ_UPPER_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> prdata[7:6] == 2'b00)
    else $error("reserved bits read nonzero");
  AST_ONE_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && st_r.phase == SGPIO_IDLE |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
  AST_DIR_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && pready && paddr == `SGPIO_OFF_DIR |=> st_r.dir == $past(pwdata[5:0]))
    else $error("direction write lost");

  // a request is taken in its setup cycle; a write lands at the edge where pready is high
  logic chk_setup;
  logic chk_commit;
  assign chk_setup  = psel && !penable && (st_r.phase == SGPIO_IDLE);
  assign chk_commit = psel && penable && pwrite && pready;

  // pad drive, all pins at once; the cell flop puts one cycle between register and pin
  AST_OE_ALL_PINS: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |=> pin_oe == ~$past(st_r.dir))
    else $error("output enable not the inverse of direction");
  AST_OUT_ALL_PINS: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |=> pin_o == $past(st_r.latch))
    else $error("pin output not the latch value");
  AST_OE_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
    $stable(st_r.dir)
    |=> $stable(pin_oe))
    else $error("output enable moved without direction change");
  AST_OUT_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
    $stable(st_r.latch)
    |=> $stable(pin_o))
    else $error("pin output moved without latch change");
  AST_ANALOG_OE_UNTOUCHED: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(st_r.analog) && $stable(st_r.dir)
    |=> $stable(pin_oe))
    else $error("analog select changed output enable");
  AST_ANALOG_OUT_UNTOUCHED: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(st_r.analog) && $stable(st_r.latch)
    |=> $stable(pin_o))
    else $error("analog select changed pin output");

  // input path
  AST_ANALOG_ALL_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |=> (levels & $past(st_r.analog)) == 6'h00)
    else $error("analog pin level not zero");
  AST_DIGITAL_ALL_PINS: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |=> (levels | $past(st_r.analog)) == ($past(pin_i) | $past(st_r.analog)))
    else $error("digital level differs from pin");
  AST_LEVELS_NEED_PIN: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |=> (levels & ~$past(pin_i)) == 6'h00)
    else $error("level high while pin was low");

  // bus answer; a reset mid-transfer drops the answer, so these stay under the disable
  AST_READY_ONE_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    pready
    |=> !pready)
    else $error("ready held longer than one cycle");
  AST_READY_NEEDS_SETUP: assert property (@(posedge pclk) disable iff (!presetn)
    !chk_setup
    |=> !pready)
    else $error("ready without a setup cycle");
  AST_READY_IS_ACCESS: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |-> pready == (st_r.phase == SGPIO_ACCESS))
    else $error("ready and access phase disagree");
  AST_PHASE_LEGAL: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |-> (st_r.phase == SGPIO_IDLE) || (st_r.phase == SGPIO_ACCESS))
    else $error("bus phase code illegal");
  AST_ACCESS_ENDS: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.phase == SGPIO_ACCESS
    |=> st_r.phase == SGPIO_IDLE)
    else $error("access phase longer than one cycle");
  AST_PHASE_AFTER_SETUP: assert property (@(posedge pclk) disable iff (!presetn)
    chk_setup
    |=> st_r.phase == SGPIO_ACCESS)
    else $error("setup not followed by access");
  AST_IDLE_WITHOUT_SETUP: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.phase == SGPIO_IDLE && !chk_setup
    |=> st_r.phase == SGPIO_IDLE)
    else $error("access phase without setup");
  AST_ERR_ONLY_WITH_READY: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr
    |-> pready)
    else $error("error flag without ready");
  AST_ERR_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
    chk_setup && !addr_hit(paddr)
    |=> pslverr)
    else $error("unmapped address not flagged");
  AST_NO_ERR_MAPPED: assert property (@(posedge pclk) disable iff (!presetn)
    chk_setup && addr_hit(paddr)
    |=> !pslverr)
    else $error("mapped address flagged");
  AST_RDATA_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
    !chk_setup
    |=> $stable(prdata))
    else $error("read data moved without a request");

  // read data
  AST_READ_DATA_LEVELS: assert property (@(posedge pclk) disable iff (!presetn)
    chk_setup && !pwrite && (paddr == `SGPIO_OFF_DATA)
    |=> prdata == {26'h0, $past(levels)})
    else $error("data read not the pin levels");
  AST_READ_DIR_BITS: assert property (@(posedge pclk) disable iff (!presetn)
    chk_setup && !pwrite && (paddr == `SGPIO_OFF_DIR)
    |=> prdata == {26'h0, $past(st_r.dir)})
    else $error("direction read wrong");
  AST_READ_ANALOG_BITS: assert property (@(posedge pclk) disable iff (!presetn)
    chk_setup && !pwrite && (paddr == `SGPIO_OFF_ANALOG)
    |=> prdata == {26'h0, $past(st_r.analog)})
    else $error("analog select read wrong");
  AST_READ_STATUS_BITS: assert property (@(posedge pclk) disable iff (!presetn)
    chk_setup && !pwrite && (paddr == `SGPIO_OFF_STATUS)
    |=> prdata == {26'h0, $past(pin_oe)})
    else $error("status read wrong");
  AST_READ_UNMAPPED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    chk_setup && !pwrite && !addr_hit(paddr)
    |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  AST_WRITE_ANSWER_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    chk_setup && pwrite
    |=> prdata == 32'h0000_0000)
    else $error("write answer carried data");
  AST_UPPER_BITS_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1
    |-> prdata[31:6] == 26'h0)
    else $error("unimplemented read bits nonzero");

  // register writes; a write whose address misses must leave every register untouched
  AST_DATA_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    chk_commit && (paddr == `SGPIO_OFF_DATA)
    |=> st_r.latch == $past(pwdata[5:0]))
    else $error("data write lost");
  AST_ANALOG_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    chk_commit && (paddr == `SGPIO_OFF_ANALOG)
    |=> st_r.analog == $past(pwdata[5:0]))
    else $error("analog select write lost");
  AST_LATCH_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
    !(chk_commit && (paddr == `SGPIO_OFF_DATA))
    |=> $stable(st_r.latch))
    else $error("latch changed without a data write");
  AST_DIR_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
    !(chk_commit && (paddr == `SGPIO_OFF_DIR))
    |=> $stable(st_r.dir))
    else $error("direction changed without a write");
  AST_ANALOG_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
    !(chk_commit && (paddr == `SGPIO_OFF_ANALOG))
    |=> $stable(st_r.analog))
    else $error("analog select changed without a write");
  AST_STATUS_WRITE_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
    chk_commit && (paddr == `SGPIO_OFF_STATUS)
    |=> $stable(st_r.dir) && $stable(st_r.latch) && $stable(st_r.analog))
    else $error("status write changed a register");
  AST_STRAY_WRITE_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
    chk_commit && !addr_hit(paddr)
    |=> $stable(st_r.dir) && $stable(st_r.latch) && $stable(st_r.analog))
    else $error("unmapped write changed a register");
  AST_READ_KEEPS_REGS: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite && pready
    |=> $stable(st_r.dir) && $stable(st_r.latch) && $stable(st_r.analog))
    else $error("read changed a register");
endmodule
`default_nettype wire

// ==== tb/sgpio_pad_model.sv ====
`default_nettype none
module sgpio_pad_model (
  // pad
  input  wire logic [5:0] pin_o,
  input  wire logic [5:0] pin_oe,
  input  wire logic [5:0] ext,
  output var  logic [5:0] pin_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // a driven pin shows its own level, a released one the outside source
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext);
endmodule
`default_nettype wire

// ==== tb/test_six_pin_gpio_port.sv ====
`default_nettype none
module test_six_pin_gpio_port;
  import sgpio_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, dir, lat, ana;
  logic [5:0]  pin_i, pin_o, pin_oe, ext;
  int          n_fail, checked;
  sgpio_port i_sgpio_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe));
  sgpio_pad_model i_sgpio_pad_model (.pin_o(pin_o), .pin_oe(pin_oe), .ext(ext), .pin_i(pin_i));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  function automatic logic [31:0] exp_data(logic [5:0] d, l, a, e);
    return {26'h0, ((~d & l) | (d & e)) & ~a};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no answer time is assumed here: a hang is left to the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    complete_run;
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    ext = 6'h2A;
    void'($urandom(32'hA91880D3));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    chk("dir reset", 32'h3F, rd);
    apb(1'b0, 12'h000, 32'h0);
    chk("analog data", 32'h0, rd);
    apb(1'b1, 12'h010, 32'hFFFFFFFF);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped data", 32'h0, rd);
    for (int i = 0; i < 40; i++) begin
      dir = (i == 0) ? 32'hFFFFFFC0 : $urandom;
      lat = $urandom;
      ana = (i < 20) ? 32'h0 : $urandom;
      ext <= 6'($urandom);
      apb(1'b1, 12'h008, ana);
      apb(1'b1, 12'h000, lat);
      apb(1'b1, 12'h004, dir);
      repeat (3) @(posedge pclk);
      chk("pin_oe", {26'h0, ~dir[5:0]}, {26'h0, pin_oe});
      chk("pin_o", {26'h0, lat[5:0] & ~dir[5:0]}, {26'h0, pin_o & ~dir[5:0]});
      apb(1'b0, 12'h004, 32'h0);
      chk("dir", dir & 32'h3F, rd);
      chk("dir err", 32'h0, {31'h0, err});
      apb(1'b0, 12'h000, 32'h0);
      chk("data", exp_data(dir[5:0], lat[5:0], ana[5:0], ext), rd);
      apb(1'b0, 12'h008, 32'h0);
      chk("analog", ana & 32'h3F, rd);
      apb(1'b0, 12'h00C, 32'h0);
      chk("status", {26'h0, ~dir[5:0]}, rd);
    end
    complete_run;
  end
endmodule
`default_nettype wire
